// ---- srts_cfg.svh ----
// constants of the sequence trigger block: offsets, fields, reset values
`ifndef SRTS_CFG_SVH
`define SRTS_CFG_SVH

`define SRTS_NUM_ENTRIES 10
`define SRTS_IDX_W 4
`define SRTS_NEXT_OFF 4'hF

// entry field widths
`define SRTS_WIDTH_W 13
`define SRTS_HEIGHT_W 12
`define SRTS_GAIN_W 16
`define SRTS_EXPO_W 24
`define SRTS_BLACK_W 9
`define SRTS_COUNT_W 8

// entry defaults after reset
`define SRTS_DEF_WIDTH 13'h1400
`define SRTS_DEF_HEIGHT 12'hF00
`define SRTS_DEF_GAIN 16'h0064
`define SRTS_DEF_EXPO 24'h02BF20
`define SRTS_DEF_COUNT 8'h01
`define SRTS_DEF_NEXT 4'h0

// register byte offsets
`define SRTS_REG_CTRL 8'h00
`define SRTS_REG_NEXT_CMD 8'h04
`define SRTS_REG_SELECT 8'h08
`define SRTS_REG_WIDTH 8'h0C
`define SRTS_REG_HEIGHT 8'h10
`define SRTS_REG_OFFSET_X 8'h14
`define SRTS_REG_OFFSET_Y 8'h18
`define SRTS_REG_GAIN 8'h1C
`define SRTS_REG_RED_BLUE 8'h20
`define SRTS_REG_EXPOSURE 8'h24
`define SRTS_REG_BLACK 8'h28
`define SRTS_REG_MISC 8'h2C
`define SRTS_REG_STATUS 8'h30

// control register fields
`define SRTS_CTRL_RUN 0
`define SRTS_CTRL_MODE_LO 1
`define SRTS_CTRL_MODE_HI 2
`define SRTS_CTRL_REPEAT 3

// misc register fields
`define SRTS_MISC_BIN_H 0
`define SRTS_MISC_BIN_V 1
`define SRTS_MISC_LUT 2
`define SRTS_MISC_COUNT_LO 8
`define SRTS_MISC_COUNT_HI 15
`define SRTS_MISC_NEXT_LO 16
`define SRTS_MISC_NEXT_HI 19

`endif

// ---- srts_checker.sv ----
// port assertions for the sequence trigger block
`timescale 1ns/100ps
module srts_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // trigger side
  input wire logic trigger_in,
  input wire logic capture_done,
  input wire logic frame_start,
  input wire logic capture_busy,
  input wire logic [3:0] cap_index,
  input wire logic [23:0] cap_exposure
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_start_cause: assert property
    (frame_start |-> $past(trigger_in, 2) && !$past(trigger_in, 3))
    else $error("frame start without trigger edge");
  a_start_pulse: assert property
    (frame_start |=> !frame_start && capture_busy)
    else $error("frame start not a pulse into busy");
  a_busy_hold: assert property
    (capture_busy && !capture_done |=> capture_busy)
    else $error("busy dropped before done");
  a_busy_end: assert property (capture_busy && capture_done |=> !capture_busy)
    else $error("busy stuck after done");
  a_no_restart: assert property
    (capture_busy |=> !frame_start ##1 !frame_start)
    else $error("capture restarted while busy");
  a_params_stable: assert property
    (!frame_start |-> $stable(cap_index) && $stable(cap_exposure))
    else $error("capture parameters moved between frames");

  c_frame: cover property (frame_start);
  c_err: cover property (pslverr);
  c_busy_trig: cover property (capture_busy && $rose(trigger_in));
endmodule : srts_checker

// ---- srts_pkg.sv ----
// types of the sequence trigger block
`include "srts_cfg.svh"
package srts_pkg;

  typedef struct packed {
    logic [`SRTS_WIDTH_W-1:0] width;
    logic [`SRTS_HEIGHT_W-1:0] height;
    logic [`SRTS_WIDTH_W-1:0] offset_x;
    logic [`SRTS_HEIGHT_W-1:0] offset_y;
    logic [`SRTS_GAIN_W-1:0] gain;
    logic [`SRTS_GAIN_W-1:0] red;
    logic [`SRTS_GAIN_W-1:0] blue;
    logic [`SRTS_EXPO_W-1:0] exposure;
    logic [`SRTS_BLACK_W-1:0] black_level;
    logic bin_h;
    logic bin_v;
    logic lookup_table_on;
    logic [`SRTS_COUNT_W-1:0] frame_count;
    logic [`SRTS_IDX_W-1:0] next_index;
  } srts_entry_type;

  typedef enum logic [1:0] {
    SRTS_MODE_NORMAL,
    SRTS_MODE_TRIGGER,
    SRTS_MODE_COMMAND,
    SRTS_MODE_MULTI
  } srts_mode_type;

  typedef enum logic [1:0] {
    SRTS_ST_IDLE,
    SRTS_ST_FETCH,
    SRTS_ST_CAPTURE,
    SRTS_ST_STOPPED
  } srts_state_type;

  localparam srts_entry_type SRTS_DEFAULT_ENTRY = '{
    width: `SRTS_DEF_WIDTH,
    height: `SRTS_DEF_HEIGHT,
    offset_x: '0,
    offset_y: '0,
    gain: `SRTS_DEF_GAIN,
    red: '0,
    blue: '0,
    exposure: `SRTS_DEF_EXPO,
    black_level: '0,
    bin_h: 1'b0,
    bin_v: 1'b0,
    lookup_table_on: 1'b0,
    frame_count: `SRTS_DEF_COUNT,
    next_index: `SRTS_DEF_NEXT
  };

endpackage : srts_pkg

// ---- srts_sequencer.sv ----
// sequence trigger block: apb registers, index table and frame sequencer
`timescale 1ns/100ps
`include "srts_cfg.svh"
module srts_sequencer #(
  parameter int N_ENTRIES = `SRTS_NUM_ENTRIES
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger side
  input wire logic trigger_in,
  input wire logic capture_done,
  // capture parameters
  output logic frame_start,
  output logic capture_busy,
  output logic [`SRTS_IDX_W-1:0] cap_index,
  output logic [`SRTS_WIDTH_W-1:0] cap_width,
  output logic [`SRTS_HEIGHT_W-1:0] cap_height,
  output logic [`SRTS_WIDTH_W-1:0] cap_offset_x,
  output logic [`SRTS_HEIGHT_W-1:0] cap_offset_y,
  output logic [`SRTS_GAIN_W-1:0] cap_gain,
  output logic [`SRTS_GAIN_W-1:0] cap_red,
  output logic [`SRTS_GAIN_W-1:0] cap_blue,
  output logic [`SRTS_EXPO_W-1:0] cap_exposure,
  output logic [`SRTS_BLACK_W-1:0] cap_black_level,
  output logic cap_bin_h,
  output logic cap_bin_v,
  output logic cap_lookup_table_on
);

  if (N_ENTRIES < 1 || N_ENTRIES > 15)
    $error("N_ENTRIES must be 1 to 15");

  localparam logic [`SRTS_IDX_W-1:0] LAST_IDX = `SRTS_IDX_W'(N_ENTRIES - 1);

  // apb and software registers
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic run_q, run_d;
  srts_pkg::srts_mode_type mode_q, mode_d;
  logic repeat_q, repeat_d;
  logic [`SRTS_IDX_W-1:0] cmd_idx_q, cmd_idx_d;
  logic [`SRTS_IDX_W-1:0] sel_q, sel_d;
  logic wr_en;
  srts_pkg::srts_entry_type wr_data, wr_mask, rd_a, rd_b;

  // sequencer state
  srts_pkg::srts_state_type state_q, state_d;
  logic [`SRTS_IDX_W-1:0] idx_q, idx_d;
  logic [`SRTS_COUNT_W-1:0] rep_q, rep_d;
  logic trig_q;
  logic busy_q, busy_d;
  logic start_q, start_d;
  logic [`SRTS_IDX_W-1:0] cap_idx_q, cap_idx_d;
  srts_pkg::srts_entry_type par_q, par_d;

  logic access, commit, trig_rise, seq_mode;
  logic [`SRTS_IDX_W-1:0] run_idx;

  assign access = psel && penable;
  assign commit = access && pready_q;
  assign trig_rise = trigger_in && !trig_q;
  assign seq_mode = (mode_q == srts_pkg::SRTS_MODE_TRIGGER) ||
                    (mode_q == srts_pkg::SRTS_MODE_COMMAND);
  // command order reads the commanded index, trigger order its own pointer
  assign run_idx = (mode_q == srts_pkg::SRTS_MODE_COMMAND) ? cmd_idx_q
                                                           : idx_q;

  srts_table_mem #(
    .N_ENTRIES(N_ENTRIES)
  ) u_table (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en),
    .wr_idx(sel_q),
    .wr_data(wr_data),
    .wr_mask(wr_mask),
    .rd_a_idx(sel_q),
    .rd_a_data(rd_a),
    .rd_b_idx(run_idx),
    .rd_b_data(rd_b)
  );

  // register access: one wait cycle, effect at the completing edge
  always_comb
  begin
    pready_d = access && !pready_q;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    run_d = run_q;
    mode_d = mode_q;
    repeat_d = repeat_q;
    cmd_idx_d = cmd_idx_q;
    sel_d = sel_q;
    wr_en = 1'b0;
    wr_data = '0;
    wr_mask = '0;
    if (access && !pready_q)
    begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        `SRTS_REG_CTRL:
          prdata_d = {28'h0, repeat_q, mode_q, run_q};
        `SRTS_REG_NEXT_CMD:
          prdata_d = {28'h0, cmd_idx_q};
        `SRTS_REG_SELECT:
          prdata_d = {28'h0, sel_q};
        `SRTS_REG_WIDTH:
          prdata_d = {19'h0, rd_a.width};
        `SRTS_REG_HEIGHT:
          prdata_d = {20'h0, rd_a.height};
        `SRTS_REG_OFFSET_X:
          prdata_d = {19'h0, rd_a.offset_x};
        `SRTS_REG_OFFSET_Y:
          prdata_d = {20'h0, rd_a.offset_y};
        `SRTS_REG_GAIN:
          prdata_d = {16'h0, rd_a.gain};
        `SRTS_REG_RED_BLUE:
          prdata_d = {rd_a.blue, rd_a.red};
        `SRTS_REG_EXPOSURE:
          prdata_d = {8'h0, rd_a.exposure};
        `SRTS_REG_BLACK:
          prdata_d = {23'h0, rd_a.black_level};
        `SRTS_REG_MISC:
          prdata_d = {12'h0, rd_a.next_index, rd_a.frame_count, 5'h0,
                      rd_a.lookup_table_on, rd_a.bin_v, rd_a.bin_h};
        `SRTS_REG_STATUS:
          prdata_d = {16'h0, rep_q, idx_q, 1'b0,
                      state_q == srts_pkg::SRTS_ST_STOPPED,
                      run_q && seq_mode,
                      state_q == srts_pkg::SRTS_ST_CAPTURE};
        default:
          pslverr_d = 1'b1;
      endcase
    end
    if (commit && pwrite && !pslverr_q)
    begin
      unique case (paddr)
        `SRTS_REG_CTRL:
        begin
          run_d = pwdata[`SRTS_CTRL_RUN];
          mode_d = srts_pkg::srts_mode_type'(
                     pwdata[`SRTS_CTRL_MODE_HI:`SRTS_CTRL_MODE_LO]);
          repeat_d = pwdata[`SRTS_CTRL_REPEAT];
        end
        `SRTS_REG_NEXT_CMD:
          if (pwdata[`SRTS_IDX_W-1:0] <= LAST_IDX)
            cmd_idx_d = pwdata[`SRTS_IDX_W-1:0];
        `SRTS_REG_SELECT:
          if (pwdata[`SRTS_IDX_W-1:0] <= LAST_IDX)
            sel_d = pwdata[`SRTS_IDX_W-1:0];
        `SRTS_REG_WIDTH:
        begin
          wr_data.width = pwdata[`SRTS_WIDTH_W-1:0];
          wr_mask.width = '1;
        end
        `SRTS_REG_HEIGHT:
        begin
          wr_data.height = pwdata[`SRTS_HEIGHT_W-1:0];
          wr_mask.height = '1;
        end
        `SRTS_REG_OFFSET_X:
        begin
          wr_data.offset_x = pwdata[`SRTS_WIDTH_W-1:0];
          wr_mask.offset_x = '1;
        end
        `SRTS_REG_OFFSET_Y:
        begin
          wr_data.offset_y = pwdata[`SRTS_HEIGHT_W-1:0];
          wr_mask.offset_y = '1;
        end
        `SRTS_REG_GAIN:
        begin
          wr_data.gain = pwdata[`SRTS_GAIN_W-1:0];
          wr_mask.gain = '1;
        end
        `SRTS_REG_RED_BLUE:
        begin
          wr_data.red = pwdata[15:0];
          wr_data.blue = pwdata[31:16];
          wr_mask.red = '1;
          wr_mask.blue = '1;
        end
        `SRTS_REG_EXPOSURE:
        begin
          wr_data.exposure = pwdata[`SRTS_EXPO_W-1:0];
          wr_mask.exposure = '1;
        end
        `SRTS_REG_BLACK:
        begin
          wr_data.black_level = pwdata[`SRTS_BLACK_W-1:0];
          wr_mask.black_level = '1;
        end
        `SRTS_REG_MISC:
        begin
          wr_data.bin_h = pwdata[`SRTS_MISC_BIN_H];
          wr_data.bin_v = pwdata[`SRTS_MISC_BIN_V];
          wr_data.lookup_table_on = pwdata[`SRTS_MISC_LUT];
          wr_data.frame_count =
            pwdata[`SRTS_MISC_COUNT_HI:`SRTS_MISC_COUNT_LO];
          wr_data.next_index = pwdata[`SRTS_MISC_NEXT_HI:`SRTS_MISC_NEXT_LO];
          wr_mask.bin_h = 1'b1;
          wr_mask.bin_v = 1'b1;
          wr_mask.lookup_table_on = 1'b1;
          wr_mask.frame_count = '1;
          wr_mask.next_index = '1;
        end
        default:
        begin
        end
      endcase
      wr_en = (wr_mask != '0);
    end
  end

  // sequencer: arm, fetch entry, capture until done, then step
  always_comb
  begin
    state_d = state_q;
    idx_d = idx_q;
    rep_d = rep_q;
    start_d = 1'b0;
    cap_idx_d = cap_idx_q;
    par_d = par_q;
    if (!run_q || !seq_mode)
    begin
      // stopping acquisition rewinds the trigger order to index zero
      state_d = srts_pkg::SRTS_ST_IDLE;
      idx_d = '0;
      rep_d = '0;
    end
    else
    begin
      unique case (state_q)
        srts_pkg::SRTS_ST_IDLE:
          if (trig_rise)
            state_d = srts_pkg::SRTS_ST_FETCH;
        srts_pkg::SRTS_ST_FETCH:
        begin
          par_d = rd_b;
          cap_idx_d = run_idx;
          start_d = 1'b1;
          state_d = srts_pkg::SRTS_ST_CAPTURE;
        end
        srts_pkg::SRTS_ST_CAPTURE:
          // new trigger edges are not looked at here
          if (capture_done)
          begin
            state_d = srts_pkg::SRTS_ST_IDLE;
            if (mode_q == srts_pkg::SRTS_MODE_TRIGGER)
            begin
              if ({1'b0, rep_q} + 9'h001 >= {1'b0, par_q.frame_count})
              begin
                rep_d = '0;
                if (par_q.next_index == `SRTS_NEXT_OFF)
                begin
                  idx_d = '0;
                  if (!repeat_q)
                    state_d = srts_pkg::SRTS_ST_STOPPED;
                end
                else if (par_q.next_index <= LAST_IDX)
                  idx_d = par_q.next_index;
                else
                  idx_d = '0;
              end
              else
                rep_d = rep_q + 8'h01;
            end
            // command order keeps no count or successor
            else
            begin
              rep_d = '0;
            end
          end
        srts_pkg::SRTS_ST_STOPPED:
          state_d = srts_pkg::SRTS_ST_STOPPED;
      endcase
    end
    busy_d = (state_d == srts_pkg::SRTS_ST_CAPTURE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      run_q <= 1'b0;
      mode_q <= srts_pkg::SRTS_MODE_NORMAL;
      repeat_q <= 1'b0;
      cmd_idx_q <= '0;
      sel_q <= '0;
      state_q <= srts_pkg::SRTS_ST_IDLE;
      idx_q <= '0;
      rep_q <= '0;
      trig_q <= 1'b0;
      busy_q <= 1'b0;
      start_q <= 1'b0;
      cap_idx_q <= '0;
      par_q <= srts_pkg::SRTS_DEFAULT_ENTRY;
    end
    else
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      run_q <= run_d;
      mode_q <= mode_d;
      repeat_q <= repeat_d;
      cmd_idx_q <= cmd_idx_d;
      sel_q <= sel_d;
      state_q <= state_d;
      idx_q <= idx_d;
      rep_q <= rep_d;
      trig_q <= trigger_in;
      busy_q <= busy_d;
      start_q <= start_d;
      cap_idx_q <= cap_idx_d;
      par_q <= par_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign frame_start = start_q;
  assign capture_busy = busy_q;
  assign cap_index = cap_idx_q;
  assign cap_width = par_q.width;
  assign cap_height = par_q.height;
  assign cap_offset_x = par_q.offset_x;
  assign cap_offset_y = par_q.offset_y;
  assign cap_gain = par_q.gain;
  assign cap_red = par_q.red;
  assign cap_blue = par_q.blue;
  assign cap_exposure = par_q.exposure;
  assign cap_black_level = par_q.black_level;
  assign cap_bin_h = par_q.bin_h;
  assign cap_bin_v = par_q.bin_v;
  assign cap_lookup_table_on = par_q.lookup_table_on;

endmodule : srts_sequencer

// ---- srts_table_mem.sv ----
// index table: masked write port and two registered read ports
`timescale 1ns/100ps
`include "srts_cfg.svh"
module srts_table_mem #(
  parameter int N_ENTRIES = `SRTS_NUM_ENTRIES
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port, bits set in wr_mask are replaced
  input wire logic wr_en,
  input wire logic [`SRTS_IDX_W-1:0] wr_idx,
  input wire srts_pkg::srts_entry_type wr_data,
  input wire srts_pkg::srts_entry_type wr_mask,
  // software read port
  input wire logic [`SRTS_IDX_W-1:0] rd_a_idx,
  output srts_pkg::srts_entry_type rd_a_data,
  // sequencer read port
  input wire logic [`SRTS_IDX_W-1:0] rd_b_idx,
  output srts_pkg::srts_entry_type rd_b_data
);

  srts_pkg::srts_entry_type mem_q [N_ENTRIES];
  srts_pkg::srts_entry_type mem_d [N_ENTRIES];
  srts_pkg::srts_entry_type rd_a_q;
  srts_pkg::srts_entry_type rd_b_q;

  always_comb
  begin
    for (int i = 0; i < N_ENTRIES; i++)
    begin
      mem_d[i] = mem_q[i];
      if (wr_en && (int'(wr_idx) == i))
        mem_d[i] = (mem_q[i] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // every entry starts from the same defaults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < N_ENTRIES; i++)
        mem_q[i] <= srts_pkg::SRTS_DEFAULT_ENTRY;
      rd_a_q <= srts_pkg::SRTS_DEFAULT_ENTRY;
      rd_b_q <= srts_pkg::SRTS_DEFAULT_ENTRY;
    end
    else
    begin
      mem_q <= mem_d;
      rd_a_q <= (int'(rd_a_idx) < N_ENTRIES) ? mem_q[rd_a_idx] : '0;
      rd_b_q <= (int'(rd_b_idx) < N_ENTRIES) ? mem_q[rd_b_idx] : '0;
    end
  end

  assign rd_a_data = rd_a_q;
  assign rd_b_data = rd_b_q;

endmodule : srts_table_mem

// ---- srts_trig_src.sv ----
// trigger source and capture path model facing the sequencer
`timescale 1ns/100ps
module srts_trig_src #(
  parameter int DONE_DLY = 12
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench commands
  input wire logic fire,
  input wire logic early,
  // block side
  input wire logic frame_start,
  output logic trigger_in,
  output logic capture_done
);
  int hold_q;
  int cap_q;
  // scaled frame time stands in for spacing, exposure allowance
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_q <= 0;
      cap_q <= 0;
      trigger_in <= 1'b0;
      capture_done <= 1'b0;
    end
    else
    begin
      capture_done <= (cap_q == 1); // no readout overlap
      if (fire)
        hold_q <= 3;
      else if (hold_q > 0)
        hold_q <= hold_q - 1;
      if (frame_start)
        cap_q <= DONE_DLY;
      else if (cap_q > 0)
        cap_q <= cap_q - 1;
      // early fires mid capture only when the bench commands it
      trigger_in <= fire || hold_q > 1 || (early && cap_q == DONE_DLY / 2);
    end
  end
endmodule : srts_trig_src

// ---- tb_top.sv ----
// self-checking bench for the sequence trigger block
`timescale 1ns/100ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, idx, ex;
  logic trigger_in, capture_done, frame_start, capture_busy, fire, early;
  logic got, e;
  logic [3:0] cap_index;
  logic [23:0] cap_exposure;
  logic [12:0] cw, cox;
  logic [11:0] ch, coy;
  logic [15:0] cg, cr, cb;
  logic [8:0] cbl;
  logic bh, bv, lt;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] r_addr [10] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18,
    8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
  logic [31:0] r_exp [10] = '{32'h0, 32'h1400, 32'hF00, 32'h0, 32'h0,
    32'h64, 32'h0, 32'h2BF20, 32'h0, 32'h100};
  logic [31:0] c_cmd [4] = '{32'h3, 32'h7, 32'h7, 32'hC};
  logic [31:0] c_exp [4] = '{32'h3, 32'h7, 32'h7, 32'h7};

  srts_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_in(trigger_in), .capture_done(capture_done),
    .frame_start(frame_start), .capture_busy(capture_busy),
    .cap_index(cap_index), .cap_width(cw), .cap_height(ch),
    .cap_offset_x(cox), .cap_offset_y(coy), .cap_gain(cg), .cap_red(cr),
    .cap_blue(cb), .cap_exposure(cap_exposure), .cap_black_level(cbl),
    .cap_bin_h(bh), .cap_bin_v(bv), .cap_lookup_table_on(lt));
  srts_trig_src i_src (.pclk(pclk), .presetn(presetn), .fire(fire),
    .early(early), .frame_start(frame_start), .trigger_in(trigger_in),
    .capture_done(capture_done));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // the wait ends when pready is seen high, or else at the watchdog
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one trigger, then wait for the capture to finish
  task automatic trig(input logic ovl, input logic want);
    int n;
    n = 0;
    got = 1'b0;
    @(posedge pclk);
    fire <= 1'b1;
    early <= ovl;
    @(posedge pclk);
    fire <= 1'b0;
    while (!got && n < 20)
    begin
      @(negedge pclk);
      n++;
      got = (frame_start === 1'b1);
    end
    idx = {28'h0, cap_index};
    ex = {8'h0, cap_exposure};
    n = 0;
    while (got && capture_done !== 1'b1 && n < 40)
    begin
      @(negedge pclk);
      n++;
    end
    check({31'h0, got}, {31'h0, want});
    if (got)
      check({31'h0, capture_done}, 32'h1);
    repeat (3) @(posedge pclk);
    early <= 1'b0;
  endtask : trig

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, fire, early} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({28'h0, cap_index}, 32'h0);
    check({8'h0, cap_exposure}, 32'h2BF20);
    check({7'h0, cw, ch}, 32'h0140_0F00);
    check({7'h0, cox, coy}, 32'h0);
    check({cr, cb}, 32'h0);
    check({16'h0, cg}, 32'h64);
    check({20'h0, cbl, bh, bv, lt}, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b1, 8'h08, i);
      for (int r = 0; r < 10; r++)
      begin
        apb(1'b0, r_addr[r], 32'h0);
        check(rd, r_exp[r]);
      end
    end
    $display("defaults test done");
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h2C, 32'h0003_0200);
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b1, 8'h24, 32'h55);
    apb(1'b1, 8'h2C, 32'h000F_0104);
    apb(1'b1, 8'h00, 32'h3);
    trig(1'b1, 1'b1);
    check(idx, 32'h0);
    check(ex, 32'h2BF20);
    trig(1'b0, 1'b1);
    check(idx, 32'h0);
    trig(1'b0, 1'b1);
    check(idx, 32'h3);
    check(ex, 32'h55);
    check({31'h0, lt}, 32'h1);
    trig(1'b0, 1'b0);
    check({31'h0, got}, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, rd[2]}, 32'h1);
    $display("trigger order test done");
    // a stopped sequence leaves its halt when run is cleared or the mode leaves trigger and command order
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'h5);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, 8'h04, c_cmd[k]);
      trig(1'b0, 1'b1);
      check(idx, c_exp[k]);
    end
    $display("command order test done");
    apb(1'b0, 8'hFC, 32'h0);
    check({31'h0, e}, 32'h1);
    $display("unmapped access test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({28'h0, cap_index}, 32'h0);
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b0, 8'h24, 32'h0);
    check(rd, 32'h2BF20);
    apb(1'b0, 8'h2C, 32'h0);
    check(rd, 32'h100);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule : tb_top

bind srts_sequencer srts_checker i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .trigger_in(trigger_in), .capture_done(capture_done),
  .frame_start(frame_start), .capture_busy(capture_busy),
  .cap_index(cap_index), .cap_exposure(cap_exposure));
